// [rtl/stmr_pkg.sv]
// Constants, register map and state types of the sixteen-bit timer with its oscillator.
// Assumes a 40 MHz system clock acting as the instruction clock and an Avalon-MM host.
`default_nettype none

package stmr_pkg;

    // ------------------------------------------------------------------
    // Register map, byte addresses of aligned 32-bit words
    // ------------------------------------------------------------------
    localparam int unsigned STMR_ADDR_W          = 5;
    localparam logic [4:0]  STMR_OFS_CTRL        = 5'h00;
    localparam logic [4:0]  STMR_OFS_CNT_LOW     = 5'h04;
    localparam logic [4:0]  STMR_OFS_CNT_HIGH    = 5'h08;
    localparam logic [4:0]  STMR_OFS_FLAGS       = 5'h0C;
    localparam logic [4:0]  STMR_OFS_ENABLES     = 5'h10;
    localparam logic [4:0]  STMR_OFS_PRIORITY    = 5'h14;
    localparam logic [4:0]  STMR_OFS_OSC_CTRL    = 5'h18;
    localparam logic [4:0]  STMR_OFS_GLOBAL_IRQ  = 5'h1C;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int unsigned STMR_B_WIDE          = 7;
    localparam int unsigned STMR_B_CLK_STATUS    = 6;
    localparam int unsigned STMR_B_PRESC_HI      = 5;
    localparam int unsigned STMR_B_PRESC_LO      = 4;
    localparam int unsigned STMR_B_OSC_EN        = 3;
    localparam int unsigned STMR_B_SYNC_DIS      = 2;
    localparam int unsigned STMR_B_SRC_SEL       = 1;
    localparam int unsigned STMR_B_ON            = 0;
    localparam int unsigned STMR_B_OVF_FLAG      = 0;
    localparam int unsigned STMR_B_OVF_EN        = 0;
    localparam int unsigned STMR_B_OVF_PRIO      = 0;
    localparam int unsigned STMR_B_IDLE_ON_SLEEP = 7;
    localparam int unsigned STMR_B_CLK_SEL_HI    = 1;
    localparam int unsigned STMR_B_CLK_SEL_LO    = 0;

    // ------------------------------------------------------------------
    // Values and reset values
    // ------------------------------------------------------------------
    localparam logic [1:0]  STMR_CLK_SEL_SECONDARY = 2'h1;
    localparam logic [15:0] STMR_CNT_MAX           = 16'hFFFF;
    localparam logic [15:0] STMR_CNT_RST           = 16'h0000;
    localparam logic [7:0]  STMR_BYTE_RST          = 8'h00;
    localparam logic [1:0]  STMR_CLK_SEL_RST       = 2'h0;
    localparam logic        STMR_BIT_RST           = 1'b0;
    localparam logic [2:0]  STMR_PSC_RST           = 3'h0;
    localparam logic [2:0]  STMR_PSC_MASK_1        = 3'h0;
    localparam logic [2:0]  STMR_PSC_MASK_2        = 3'h1;
    localparam logic [2:0]  STMR_PSC_MASK_4        = 3'h3;
    localparam logic [2:0]  STMR_PSC_MASK_8        = 3'h7;
    localparam logic [23:0] STMR_RDATA_PAD         = 24'h00_0000;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        STMR_MODE_PRIMARY = 2'b00,
        STMR_MODE_SECONDARY_RUN_MODE = 2'b01,
        STMR_MODE_SECONDARY_IDLE_MODE = 2'b10
    } stmr_mode_type;

    typedef struct packed {
        logic [15:0]   cnt;
        logic [7:0]    high_buf;
        logic          wide;
        logic [1:0]    presc_sel;
        logic          osc_en;
        logic          sync_dis;
        logic          src_sel;
        logic          on;
        logic          ovf_flag;
        logic          ovf_en;
        logic          ovf_prio;
        logic [7:0]    global_irq;
        logic          idle_on_sleep;
        logic [1:0]    clk_sel;
        stmr_mode_type mode;
        logic          ack;
        logic [7:0]    rdata;
        logic [3:0]    pin_sync;
    } stmr_state_type;

    typedef struct packed {
        logic [2:0] cnt;
    } stmr_psc_state_type;

endpackage

`default_nettype wire

// [rtl/stmr_presc_if.sv]
// Carrier between the timer core and its input prescaler.
// Assumes both ends run on the same system clock.
`default_nettype none

interface stmr_presc_if;
    logic       tick;
    logic       clear;
    logic [1:0] sel;
    logic       out_tick;

    modport core (output tick, output clear, output sel, input out_tick);
    modport psc  (input tick, input clear, input sel, output out_tick);
endinterface

`default_nettype wire

// [rtl/stmr_prescaler.sv]
// Input prescaler of the timer: divides counting ticks by 1, 2, 4 or 8.
// Assumes tick is a one-cycle pulse on the system clock.
`default_nettype none

module stmr_prescaler
    import stmr_pkg::*;
(
    input  wire logic clk_sys_i,
    input  wire logic srst_i,
    input  wire logic ce_i,
    stmr_presc_if.psc pif
);

    stmr_psc_state_type st_ff;
    stmr_psc_state_type nxt_st;
    logic [2:0]         mask;

    // ------------------------------------------------------------------
    // Division
    // ------------------------------------------------------------------
    always_comb
    begin
        nxt_st = st_ff;
        case (pif.sel)
            2'b00:   mask = STMR_PSC_MASK_1;
            2'b01:   mask = STMR_PSC_MASK_2;
            2'b10:   mask = STMR_PSC_MASK_4;
            default: mask = STMR_PSC_MASK_8;
        endcase
        pif.out_tick = pif.tick && ((st_ff.cnt & mask) == mask);
        if (pif.clear)
        begin
            nxt_st.cnt = STMR_PSC_RST;
        end
        else if (pif.tick)
        begin
            nxt_st.cnt = 3'(st_ff.cnt + 3'h1);
        end
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (srst_i)
        begin
            st_ff.cnt <= STMR_PSC_RST;
        end
        else if (ce_i)
        begin
            st_ff <= nxt_st;
        end
    end

endmodule

`default_nettype wire

// [rtl/stmr_top.sv]
// Sixteen-bit timer/counter with low-power oscillator control and secondary clock modes.
// Assumes an Avalon-MM master on clk_sys_i and a clock monitor on the same clock.
//
// The placing of the registers and the Avalon-MM interface to the registers were chosen for this implementation.
`default_nettype none

module stmr_top
    import stmr_pkg::*;
(
    input  wire logic                   clk_sys_i,
    input  wire logic                   srst_i,
    input  wire logic                   ce_i,
    input  wire logic [STMR_ADDR_W-1:0] avs_address_i,
    input  wire logic                   avs_read_i,
    input  wire logic                   avs_write_i,
    input  wire logic [31:0]            avs_writedata_i,
    input  wire logic [3:0]             avs_byteenable_i,
    output logic      [31:0]            avs_readdata_o,
    output logic                        avs_waitrequest_o,
    input  wire logic                   crystal_out_clock_in_pin_i,
    input  wire logic                   sleep_exec_i,
    input  wire logic                   wake_i,
    input  wire logic                   clock_monitor_en_i,
    input  wire logic                   osc_fail_i,
    output logic                        osc_run_o,
    output logic                        secondary_run_mode_o,
    output logic                        secondary_idle_mode_o,
    output logic                        sys_clock_from_counter_osc_o,
    output logic                        overflow_irq_o,
    output logic                        overflow_irq_priority_o
);

    stmr_state_type st_ff;
    stmr_state_type nxt_st;
    stmr_presc_if   pif ();

    logic       req;
    logic       rd_cap;
    logic       wr_acc;
    logic       mapped;
    logic [7:0] rd_val;
    logic [7:0] wbyte;
    logic       ext_edge;
    logic       inc;

    // ------------------------------------------------------------------
    // Prescaler
    // ------------------------------------------------------------------
    stmr_prescaler u_psc (
        .clk_sys_i (clk_sys_i),
        .srst_i    (srst_i),
        .ce_i      (ce_i),
        .pif       (pif)
    );

    // The unsynchronized path still passes the two pin flops; it only skips the
    // extra alignment stage, so it is one cycle faster but not truly clockless.
    assign ext_edge  = st_ff.sync_dis ? (st_ff.pin_sync[1] && !st_ff.pin_sync[2])
                                      : (st_ff.pin_sync[2] && !st_ff.pin_sync[3]);
    assign pif.tick  = st_ff.on && (st_ff.src_sel ? ext_edge : 1'b1);
    assign pif.sel   = st_ff.presc_sel;
    assign pif.clear = wr_acc && (avs_address_i == STMR_OFS_CNT_LOW);
    assign inc       = pif.out_tick;

    // ------------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------------
    assign req               = avs_read_i || avs_write_i;
    // Acknowledge only with the enable high, or a write taken in a frozen cycle would be lost.
    assign avs_waitrequest_o = req && !(st_ff.ack && ce_i);
    assign rd_cap            = avs_read_i && !st_ff.ack;
    assign wr_acc            = avs_write_i && st_ff.ack && avs_byteenable_i[0] && mapped;
    assign wbyte             = avs_writedata_i[7:0];
    assign avs_readdata_o    = {STMR_RDATA_PAD, st_ff.rdata};

    always_comb
    begin
        mapped = 1'b1;
        rd_val = STMR_BYTE_RST;
        if (avs_address_i == STMR_OFS_CTRL)
        begin
            rd_val[STMR_B_WIDE]                      = st_ff.wide;
            rd_val[STMR_B_CLK_STATUS]                = (st_ff.mode != STMR_MODE_PRIMARY);
            rd_val[STMR_B_PRESC_HI:STMR_B_PRESC_LO]  = st_ff.presc_sel;
            rd_val[STMR_B_OSC_EN]                    = st_ff.osc_en;
            rd_val[STMR_B_SYNC_DIS]                  = st_ff.sync_dis;
            rd_val[STMR_B_SRC_SEL]                   = st_ff.src_sel;
            rd_val[STMR_B_ON]                        = st_ff.on;
        end
        else if (avs_address_i == STMR_OFS_CNT_LOW)
        begin
            rd_val = st_ff.cnt[7:0];
        end
        else if (avs_address_i == STMR_OFS_CNT_HIGH)
        begin
            rd_val = st_ff.wide ? st_ff.high_buf : st_ff.cnt[15:8];
        end
        else if (avs_address_i == STMR_OFS_FLAGS)
        begin
            rd_val[STMR_B_OVF_FLAG] = st_ff.ovf_flag;
        end
        else if (avs_address_i == STMR_OFS_ENABLES)
        begin
            rd_val[STMR_B_OVF_EN] = st_ff.ovf_en;
        end
        else if (avs_address_i == STMR_OFS_PRIORITY)
        begin
            rd_val[STMR_B_OVF_PRIO] = st_ff.ovf_prio;
        end
        else if (avs_address_i == STMR_OFS_OSC_CTRL)
        begin
            rd_val[STMR_B_IDLE_ON_SLEEP]                 = st_ff.idle_on_sleep;
            rd_val[STMR_B_CLK_SEL_HI:STMR_B_CLK_SEL_LO]  = st_ff.clk_sel;
        end
        else if (avs_address_i == STMR_OFS_GLOBAL_IRQ)
        begin
            rd_val = st_ff.global_irq;
        end
        else
        begin
            mapped = 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb
    begin
        nxt_st          = st_ff;
        nxt_st.pin_sync = {st_ff.pin_sync[2:0], crystal_out_clock_in_pin_i};
        nxt_st.ack      = req && !st_ff.ack;

        // Read data are captured in the waited cycle, and the snapshot copy is
        // made at the same edge so both bytes come from one counter value.
        if (rd_cap)
        begin
            nxt_st.rdata = rd_val;
            if (st_ff.wide && (avs_address_i == STMR_OFS_CNT_LOW))
            begin
                nxt_st.high_buf = st_ff.cnt[15:8];
            end
        end

        if (inc)
        begin
            nxt_st.cnt = 16'(st_ff.cnt + 16'h0001);
        end

        if (wr_acc)
        begin
            if (avs_address_i == STMR_OFS_CTRL)
            begin
                nxt_st.wide      = wbyte[STMR_B_WIDE];
                nxt_st.presc_sel = wbyte[STMR_B_PRESC_HI:STMR_B_PRESC_LO];
                nxt_st.osc_en    = wbyte[STMR_B_OSC_EN];
                nxt_st.sync_dis  = wbyte[STMR_B_SYNC_DIS];
                nxt_st.src_sel   = wbyte[STMR_B_SRC_SEL];
                nxt_st.on        = wbyte[STMR_B_ON];
            end
            else if (avs_address_i == STMR_OFS_CNT_LOW)
            begin
                nxt_st.cnt[7:0]  = wbyte;
                nxt_st.cnt[15:8] = st_ff.cnt[15:8];
                if (st_ff.wide)
                begin
                    nxt_st.cnt[15:8] = st_ff.high_buf;
                end
            end
            else if (avs_address_i == STMR_OFS_CNT_HIGH)
            begin
                if (st_ff.wide)
                begin
                    nxt_st.high_buf = wbyte;
                end
                else
                begin
                    nxt_st.cnt[15:8] = wbyte;
                end
            end
            else if (avs_address_i == STMR_OFS_FLAGS)
            begin
                nxt_st.ovf_flag = wbyte[STMR_B_OVF_FLAG];
            end
            else if (avs_address_i == STMR_OFS_ENABLES)
            begin
                nxt_st.ovf_en = wbyte[STMR_B_OVF_EN];
            end
            else if (avs_address_i == STMR_OFS_PRIORITY)
            begin
                nxt_st.ovf_prio = wbyte[STMR_B_OVF_PRIO];
            end
            else if (avs_address_i == STMR_OFS_OSC_CTRL)
            begin
                nxt_st.idle_on_sleep = wbyte[STMR_B_IDLE_ON_SLEEP];
                nxt_st.clk_sel       = wbyte[STMR_B_CLK_SEL_HI:STMR_B_CLK_SEL_LO];
            end
            else if (avs_address_i == STMR_OFS_GLOBAL_IRQ)
            begin
                nxt_st.global_irq = wbyte;
            end
        end

        // A wrap in the same cycle as a software clear still leaves the flag set.
        if (inc && (st_ff.cnt == STMR_CNT_MAX))
        begin
            nxt_st.ovf_flag = 1'b1;
        end

        // Clock mode; a clock select write decides before a sleep event, and in secondary idle only a wake or a monitored oscillator failure counts.
        case (st_ff.mode)
            STMR_MODE_PRIMARY:
            begin
                if (wr_acc && (avs_address_i == STMR_OFS_OSC_CTRL)
                    && (wbyte[STMR_B_CLK_SEL_HI:STMR_B_CLK_SEL_LO] == STMR_CLK_SEL_SECONDARY))
                begin
                    nxt_st.mode = STMR_MODE_SECONDARY_RUN_MODE;
                end
            end
            STMR_MODE_SECONDARY_RUN_MODE:
            begin
                if (wr_acc && (avs_address_i == STMR_OFS_OSC_CTRL)
                    && (wbyte[STMR_B_CLK_SEL_HI:STMR_B_CLK_SEL_LO] != STMR_CLK_SEL_SECONDARY))
                begin
                    nxt_st.mode = STMR_MODE_PRIMARY;
                end
                else if (sleep_exec_i && !st_ff.idle_on_sleep)
                begin
                    nxt_st.mode = STMR_MODE_SECONDARY_IDLE_MODE;
                end
            end
            STMR_MODE_SECONDARY_IDLE_MODE:
            begin
                if (wake_i)
                begin
                    nxt_st.mode = STMR_MODE_SECONDARY_RUN_MODE;
                end
            end
            default:
            begin
                nxt_st.mode = STMR_MODE_PRIMARY;
            end
        endcase

        if (clock_monitor_en_i && osc_fail_i && (st_ff.mode != STMR_MODE_PRIMARY))
        begin
            nxt_st.mode = STMR_MODE_PRIMARY;
        end
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys_i)
    begin
        if (srst_i)
        begin
            st_ff.cnt           <= STMR_CNT_RST;
            st_ff.high_buf      <= STMR_BYTE_RST;
            st_ff.wide          <= STMR_BIT_RST;
            st_ff.presc_sel     <= STMR_CLK_SEL_RST;
            st_ff.osc_en        <= STMR_BIT_RST;
            st_ff.sync_dis      <= STMR_BIT_RST;
            st_ff.src_sel       <= STMR_BIT_RST;
            st_ff.on            <= STMR_BIT_RST;
            st_ff.ovf_flag      <= STMR_BIT_RST;
            st_ff.ovf_en        <= STMR_BIT_RST;
            st_ff.ovf_prio      <= STMR_BIT_RST;
            st_ff.global_irq    <= STMR_BYTE_RST;
            st_ff.idle_on_sleep <= STMR_BIT_RST;
            st_ff.clk_sel       <= STMR_CLK_SEL_RST;
            st_ff.mode          <= STMR_MODE_PRIMARY;
            st_ff.ack           <= STMR_BIT_RST;
            st_ff.rdata         <= STMR_BYTE_RST;
            st_ff.pin_sync      <= 4'h0;
        end
        else if (ce_i)
        begin
            st_ff <= nxt_st;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    // The oscillator enable does not look at the clock mode, so it survives sleep and idle.
    assign osc_run_o                    = st_ff.osc_en;
    assign secondary_run_mode_o         = (st_ff.mode == STMR_MODE_SECONDARY_RUN_MODE);
    assign secondary_idle_mode_o        = (st_ff.mode == STMR_MODE_SECONDARY_IDLE_MODE);
    assign sys_clock_from_counter_osc_o = (st_ff.mode != STMR_MODE_PRIMARY);
    assign overflow_irq_o               = st_ff.ovf_flag && st_ff.ovf_en;
    assign overflow_irq_priority_o      = st_ff.ovf_prio;

endmodule

`default_nettype wire

// [sim/stmr_chk.sv]
// Checker of the timer bus handshake, clock modes and interrupt gating.
// Assumes it is bound into stmr_top and sees only that module's ports.
`default_nettype none

module stmr_chk
    import stmr_pkg::*;
(
    input wire logic        clk_sys_i,
    input wire logic        srst_i,
    input wire logic        ce_i,
    input wire logic [4:0]  avs_address_i,
    input wire logic        avs_read_i,
    input wire logic        avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0]  avs_byteenable_i,
    input wire logic [31:0] avs_readdata_o,
    input wire logic        avs_waitrequest_o,
    input wire logic        crystal_out_clock_in_pin_i,
    input wire logic        sleep_exec_i,
    input wire logic        wake_i,
    input wire logic        clock_monitor_en_i,
    input wire logic        osc_fail_i,
    input wire logic        osc_run_o,
    input wire logic        secondary_run_mode_o,
    input wire logic        secondary_idle_mode_o,
    input wire logic        sys_clock_from_counter_osc_o,
    input wire logic        overflow_irq_o,
    input wire logic        overflow_irq_priority_o
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (srst_i);

    // ------------------------------------------------------------------
    // Helper logic
    // ------------------------------------------------------------------
    // The idle-on-sleep bit is shadowed here because no port shows it.
    logic wr_ok, wctl, wosc, wen, nofail, ios_ff;
    assign wr_ok  = avs_write_i & ~avs_waitrequest_o & ce_i & avs_byteenable_i[0];
    assign wctl   = wr_ok & (avs_address_i == STMR_OFS_CTRL);
    assign wosc   = wr_ok & (avs_address_i == STMR_OFS_OSC_CTRL);
    assign wen    = wr_ok & (avs_address_i == STMR_OFS_ENABLES);
    assign nofail = ~(clock_monitor_en_i & osc_fail_i);
    always_ff @(posedge clk_sys_i)
    begin
        if (srst_i)
            ios_ff <= 1'b0;
        else if (wosc)
            ios_ff <= avs_writedata_i[7];
    end

    sequence s_wait;
        (avs_read_i || avs_write_i) && avs_waitrequest_o && ce_i;
    endsequence
    sequence s_sleep;
        secondary_run_mode_o && sleep_exec_i && !ios_ff && ce_i && nofail && !wosc;
    endsequence

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    chk_one_wait: assert property (s_wait ##1 ce_i |-> !avs_waitrequest_o)
        else $error("waitrequest held longer than one cycle");
    chk_read_pad: assert property (avs_read_i && !avs_waitrequest_o |-> avs_readdata_o[31:8] == 24'h00_0000
        && (avs_address_i[1:0] == 2'b00 || avs_readdata_o == 32'h0000_0000))
        else $error("read data padding or unmapped read wrong");
    chk_osc_enable: assert property (wctl |=> osc_run_o == $past(avs_writedata_i[3]))
        else $error("oscillator run does not follow enable bit");
    chk_osc_keeps: assert property (osc_run_o && !wctl |=> osc_run_o)
        else $error("oscillator stopped without a control write");
    chk_run_enter: assert property (wosc && avs_writedata_i[1:0] == 2'b01 && !sys_clock_from_counter_osc_o
        && nofail |=> secondary_run_mode_o)
        else $error("secondary run not entered");
    chk_idle_enter: assert property (s_sleep |=> secondary_idle_mode_o)
        else $error("secondary idle not entered");
    chk_wake_run: assert property (secondary_idle_mode_o && wake_i && ce_i && nofail
        |=> secondary_run_mode_o)
        else $error("wake did not return to secondary run");
    chk_status_mode: assert property (sys_clock_from_counter_osc_o
        == (secondary_run_mode_o | secondary_idle_mode_o))
        else $error("clock status disagrees with mode");
    chk_fail_back: assert property (sys_clock_from_counter_osc_o && !nofail && ce_i
        |=> !sys_clock_from_counter_osc_o)
        else $error("status still shows timer oscillator after failure");
    chk_irq_gate: assert property (wen && !avs_writedata_i[0] |=> !overflow_irq_o)
        else $error("interrupt raised while disabled");
endmodule

bind stmr_top stmr_chk u_chk (.*);

`default_nettype wire

// [sim/tb.sv]
// Self-checking bench of the sixteen-bit timer, driven over Avalon-MM.
// Assumes the checker is bound into stmr_top by its own file.
`default_nettype none

module tb
    import stmr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic        clk_sys_i = 1'b0, srst_i = 1'b1, ce_i = 1'b1;
    logic [4:0]  avs_address_i = 5'h00;
    logic        avs_read_i = 1'b0, avs_write_i = 1'b0;
    logic [31:0] avs_writedata_i = 32'h0000_0000;
    logic [3:0]  avs_byteenable_i = 4'h1;
    logic        crystal_out_clock_in_pin_i = 1'b0, sleep_exec_i = 1'b0, wake_i = 1'b0;
    logic        clock_monitor_en_i = 1'b0, osc_fail_i = 1'b0;
    logic [31:0] avs_readdata_o;
    logic        avs_waitrequest_o, osc_run_o, secondary_run_mode_o, secondary_idle_mode_o;
    logic        sys_clock_from_counter_osc_o, overflow_irq_o, overflow_irq_priority_o;
    int          err_total = 0, checks_done = 0;
    logic [31:0] seed = 32'h2bb0, exp_q[$];
    string       nam_q[$];

    stmr_top DUT (.*);

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    task cmp(input string n, input logic [31:0] e, input logic [31:0] s);
        checks_done++;
        if (s !== e)
        begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", n, e, s);
        end
    endtask

    task summarize;
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // The request is left up after it is taken so a following call can reuse the strobe.
    task bus(input logic w, input logic [4:0] a, input logic [7:0] d);
        avs_address_i <= a;
        avs_read_i <= !w;
        avs_write_i <= w;
        avs_writedata_i <= {24'h00_0000, d};
        do @(posedge clk_sys_i); while (avs_waitrequest_o !== 1'b0);
    endtask
    task wr(input logic [4:0] a, input logic [7:0] d);
        bus(1'b1, a, d);
    endtask
    task rd(input logic [4:0] a, input logic [7:0] e, input string n);
        exp_q.push_back({24'h00_0000, e});
        nam_q.push_back(n);
        bus(1'b0, a, 8'h00);
    endtask
    task idle(input int n);
        avs_read_i <= 1'b0;
        avs_write_i <= 1'b0;
        repeat (n) @(posedge clk_sys_i);
    endtask
    task pulse(input logic wk);
        sleep_exec_i <= !wk;
        wake_i <= wk;
        idle(1);
        sleep_exec_i <= 1'b0;
        wake_i <= 1'b0;
        idle(1);
    endtask

    always @(posedge clk_sys_i)
        if (avs_read_i && avs_waitrequest_o === 1'b0 && exp_q.size() > 0)
            cmp(nam_q.pop_front(), exp_q.pop_front(), avs_readdata_o);

    initial
    begin
        forever #12.5 clk_sys_i = ~clk_sys_i;
    end

    initial
    begin
        #(25 * 20000);
        err_total++;
        summarize;
    end

    initial
    begin
        repeat (10) @(posedge clk_sys_i);
        srst_i <= 1'b0;
        @(posedge clk_sys_i);
        for (int i = 0; i < 8; i++) rd(5'(4 * i), 8'h00, "reset value");
        wr(5'h02, 8'h55);
        rd(5'h02, 8'h00, "unmapped");
        $display("test reset done");
        wr(STMR_OFS_CNT_HIGH, 8'hFF);
        wr(STMR_OFS_CNT_LOW, 8'hF0);
        idle(5);
        rd(STMR_OFS_CNT_HIGH, 8'hFF, "cnt high");
        rd(STMR_OFS_CNT_LOW, 8'hF0, "cnt low held");
        wr(STMR_OFS_CTRL, 8'h01);
        idle(40);
        wr(STMR_OFS_CTRL, 8'h00);
        rd(STMR_OFS_FLAGS, 8'h01, "ovf flag");
        rd(STMR_OFS_CNT_HIGH, 8'h00, "wrapped high");
        wr(STMR_OFS_ENABLES, 8'h01);
        idle(1);
        cmp("irq on", 32'h0000_0001, overflow_irq_o);
        wr(STMR_OFS_ENABLES, 8'h00);
        idle(1);
        cmp("irq masked", 32'h0000_0000, overflow_irq_o);
        wr(STMR_OFS_FLAGS, 8'h00);
        wr(STMR_OFS_ENABLES, 8'h01);
        wr(STMR_OFS_PRIORITY, 8'h01);
        idle(1);
        cmp("irq cleared", 32'h0000_0000, overflow_irq_o);
        cmp("priority", 32'h0000_0001, overflow_irq_priority_o);
        $display("test overflow done");
        for (int s = 0; s < 4; s++)
        begin
            wr(STMR_OFS_CTRL, 8'(s * 16 + 1));
            wr(STMR_OFS_CNT_LOW, 8'h00);
            idle(24);
            rd(STMR_OFS_CNT_LOW, 8'(24 >> s), "prescaled");
        end
        wr(STMR_OFS_CNT_LOW, 8'h00);
        wr(STMR_OFS_CNT_HIGH, 8'h00);
        idle(22);
        rd(STMR_OFS_CNT_LOW, 8'h03, "high write keeps prescaler");
        wr(STMR_OFS_CTRL, 8'h01);
        wr(STMR_OFS_CNT_LOW, 8'h00);
        ce_i <= 1'b0;
        idle(8);
        ce_i <= 1'b1;
        rd(STMR_OFS_CNT_LOW, 8'h00, "frozen by enable");
        $display("test prescaler done");
        seed = xs(seed);
        wr(STMR_OFS_CTRL, 8'h80);
        wr(STMR_OFS_CNT_HIGH, seed[15:8]);
        wr(STMR_OFS_CNT_LOW, seed[7:0]);
        rd(STMR_OFS_CNT_LOW, seed[7:0], "wide low");
        rd(STMR_OFS_CNT_HIGH, seed[15:8], "wide high");
        wr(STMR_OFS_CNT_HIGH, ~seed[15:8]);
        rd(STMR_OFS_CNT_LOW, seed[7:0], "wide low again");
        rd(STMR_OFS_CNT_HIGH, seed[15:8], "live high untouched");
        wr(STMR_OFS_CTRL, 8'h00);
        rd(STMR_OFS_CNT_HIGH, seed[15:8], "loaded high");
        wr(STMR_OFS_GLOBAL_IRQ, seed[23:16]);
        rd(STMR_OFS_GLOBAL_IRQ, seed[23:16], "global rw");
        $display("test wide done");
        for (int k = 0; k < 2; k++)
        begin
            wr(STMR_OFS_CNT_LOW, 8'h00);
            wr(STMR_OFS_CTRL, k ? 8'h03 : 8'h0F);
            repeat (10)
            begin
                idle(2);
                crystal_out_clock_in_pin_i <= ~crystal_out_clock_in_pin_i;
            end
            idle(6);
            wr(STMR_OFS_CTRL, 8'h00);
            rd(STMR_OFS_CNT_LOW, 8'h05, "external edges");
        end
        wr(STMR_OFS_CNT_HIGH, 8'h80);
        rd(STMR_OFS_CNT_HIGH, 8'h80, "preload high");
        rd(STMR_OFS_CNT_LOW, 8'h05, "low untouched");
        $display("test external done");
        wr(STMR_OFS_CTRL, 8'h08);
        idle(4);
        wr(STMR_OFS_OSC_CTRL, 8'h01);
        idle(1);
        cmp("secondary_run_mode", 32'h0000_0001, secondary_run_mode_o);
        rd(STMR_OFS_CTRL, 8'h48, "status set");
        pulse(1'b0);
        cmp("secondary_idle_mode", 32'h0000_0001, secondary_idle_mode_o);
        cmp("osc kept", 32'h0000_0001, osc_run_o);
        pulse(1'b1);
        cmp("woken", 32'h0000_0001, secondary_run_mode_o);
        clock_monitor_en_i <= 1'b1;
        osc_fail_i <= 1'b1;
        idle(1);
        osc_fail_i <= 1'b0;
        idle(1);
        cmp("fallback", 32'h0000_0000, sys_clock_from_counter_osc_o);
        rd(STMR_OFS_CTRL, 8'h08, "status clear");
        wr(STMR_OFS_OSC_CTRL, 8'h81);
        pulse(1'b0);
        cmp("idle on sleep", 32'h0000_0001, secondary_run_mode_o);
        wr(STMR_OFS_CTRL, 8'h00);
        idle(1);
        cmp("osc off", 32'h0000_0000, osc_run_o);
        $display("test modes done");
        idle(2);
        summarize;
    end
endmodule

`default_nettype wire
